// ==== rtl/augmented_instruction_exec.sv ====
// executor for the shift, skip, operate and in-out transfer groups
//Behaviour
//- in-out left shift code shifts the in-out register arithmetically left
//- pair rotate codes rotate accumulator plus in-out as one 36-bit ring
//- pair shift codes shift accumulator plus in-out arithmetically right or left
//- step count is the number of ones in instruction bits 9..17
//- skip selections are ORed together; instruction still takes one memory cycle
//- bit 5 set inverts the final skip decision
//- skip on accumulator zero, sign clear, or sign set
//- no-overflow skip tests overflow and clears it
//- overflow set only by arithmetic overflow, cleared by console start
//- skip when in-out register sign is zero
//- switch digit picks switch one..six or all; skip when zero
//- flag digit picks flag one..six or all; skip when zero
//- operate bits combine within one instruction
//- operate bits clear in-out, clear accumulator, complement accumulator
//- test word switches ORed into accumulator
//- load counter ORs next address, overflow, extend and extended counter
//- halt bit stops instruction execution
//- flag digit clears one or all flags; with next digit one, sets them
//- bit 5 set in transfer waits for the completion pulse
//- break or high-speed channel requests are served during the wait
//- wait-only code does nothing but wait; earlier pulse releases at once
//- completion pulse expected only when bit 6 differs from bit 5
//- in-out register is the low magnitude extension of the accumulator
//- arithmetic shifts keep the sign and fill with sign copies
//
// The AXI4-Lite register port and the register addresses were decided locally.
`timescale 1ns/10ps
module augmented_instruction_exec (
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_reset,
	// axi4-lite write address and data
	input  wire logic        i_awvalid,
	output logic             o_awready,
	input  wire logic [7:0]  i_awaddr,
	input  wire logic        i_wvalid,
	output logic             o_wready,
	input  wire logic [31:0] i_wdata,
	input  wire logic [3:0]  i_wstrb,
	// axi4-lite write response
	output logic             o_bvalid,
	input  wire logic        i_bready,
	output logic [1:0]       o_bresp,
	// axi4-lite read
	input  wire logic        i_arvalid,
	output logic             o_arready,
	input  wire logic [7:0]  i_araddr,
	output logic             o_rvalid,
	input  wire logic        i_rready,
	output logic [31:0]      o_rdata,
	output logic [1:0]       o_rresp,
	// console and arithmetic unit
	input  wire logic        i_console_start,
	input  wire logic        i_add_overflow,
	input  wire logic [17:0] i_test_word_switches,
	input  wire logic [5:0]  i_sense_switches,
	input  wire logic        i_extend_mode,
	input  wire logic [3:0]  i_extended_pc,
	// peripheral side
	input  wire logic        i_io_complete,
	input  wire logic        i_break_req,
	input  wire logic        i_hs_req,
	output logic             o_service_ack,
	output logic             o_iot_strobe,
	output logic [11:0]      o_iot_command,
	// visible machine state
	output logic [17:0]      o_ac,
	output logic [17:0]      o_io,
	output logic [11:0]      o_pc,
	output logic [5:0]       o_flags,
	output logic             o_overflow,
	output logic             o_halted,
	output logic             o_waiting
);
	localparam int EXEC_LAST = aug_exec_pkg::MEM_CYCLES - 1;

	aug_exec_pkg::state_t state_r;
	logic [aug_exec_pkg::CNT_W-1:0] cnt_r;
	logic [17:0] instr_r, ac_r, io_r, ac_nxt, io_nxt;
	logic [11:0] pc_r;
	logic [5:0]  flags_r, flags_nxt;
	logic        ovf_r, halted_r, expect_r, pend_r;
	logic        aw_full_r, w_full_r, bvalid_r, rvalid_r;
	logic [7:0]  awaddr_r;
	logic [31:0] wdata_r, rdata_r, wr_val;
	logic [3:0]  wstrb_r;
	logic [1:0]  bresp_r, rresp_r;
	logic        wr_go, idle, commit, skip_take, szo_clr, halt_go, go_wait, dev_op;
	logic [4:0]  op;

	// combining helpers
	function automatic logic [17:0] step18(input logic [17:0] v, input logic rt, input logic ar);
		if (ar)
			step18 = rt ? {v[17], v[17], v[16:1]} : {v[17], v[15:0], v[17]};
		else
			step18 = rt ? {v[0], v[17:1]} : {v[16:0], v[17]};
	endfunction

	function automatic logic [35:0] step36(input logic [35:0] v, input logic rt, input logic ar);
		if (ar)
			step36 = rt ? {v[35], v[35], v[34:1]} : {v[35], v[33:0], v[35]};
		else
			step36 = rt ? {v[0], v[35:1]} : {v[34:0], v[35]};
	endfunction

	function automatic logic [5:0] sel_mask(input logic [2:0] sel);
		sel_mask = 6'h00;
		for (int k = 0; k < 6; k++) begin
			if (sel == 3'(k + 1))
				sel_mask[k] = 1'b1;
		end
		if (sel == aug_exec_pkg::SEL_ALL)
			sel_mask = 6'h3f;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] s);
		merge = old;
		for (int b = 0; b < 4; b++) begin
			if (s[b])
				merge[b*8 +: 8] = d[b*8 +: 8];
		end
	endfunction

	assign op     = instr_r[17:13];
	assign idle   = (state_r == aug_exec_pkg::ST_IDLE);
	assign commit = (state_r == aug_exec_pkg::ST_EXEC) && (cnt_r == '0);
	assign wr_go  = aw_full_r && w_full_r && !bvalid_r;

	// instruction datapath, evaluated on the latched word
	always_comb begin
		logic [35:0] pair;
		logic        sw_hit, fl_hit;
		pair      = {ac_r, io_r};
		ac_nxt    = ac_r;
		io_nxt    = io_r;
		flags_nxt = flags_r;
		skip_take = 1'b0;
		szo_clr   = 1'b0;
		halt_go   = 1'b0;
		go_wait   = 1'b0;
		dev_op    = 1'b0;
		sw_hit    = 1'b0;
		fl_hit    = 1'b0;
		unique case (op)
			aug_exec_pkg::OP_SHIFT: begin
				// one step per set count bit equals the popcount
				for (int i = 0; i < aug_exec_pkg::SH_STEPS; i++) begin
					if (instr_r[i]) begin
						unique case (instr_r[10:9])
							aug_exec_pkg::UNIT_AC:
								ac_nxt = step18(ac_nxt, instr_r[aug_exec_pkg::SH_RIGHT],
									instr_r[aug_exec_pkg::SH_ARITH]);
							aug_exec_pkg::UNIT_IO:
								io_nxt = step18(io_nxt, instr_r[aug_exec_pkg::SH_RIGHT],
									instr_r[aug_exec_pkg::SH_ARITH]);
							aug_exec_pkg::UNIT_PAIR:
								pair = step36(pair, instr_r[aug_exec_pkg::SH_RIGHT],
									instr_r[aug_exec_pkg::SH_ARITH]);
							default: ;
						endcase
					end
				end
				if (instr_r[10:9] == aug_exec_pkg::UNIT_PAIR) begin
					ac_nxt = pair[35:18];
					io_nxt = pair[17:0];
				end
			end
			aug_exec_pkg::OP_SKIP: begin
				sw_hit = (i_sense_switches & sel_mask(instr_r[5:3])) == 6'h00;
				fl_hit = (flags_r & sel_mask(instr_r[2:0])) == 6'h00;
				skip_take = (instr_r[aug_exec_pkg::SK_ZERO] && ac_r == 18'h0_0000)
					|| (instr_r[aug_exec_pkg::SK_PLUS] && !ac_r[17])
					|| (instr_r[aug_exec_pkg::SK_MINUS] && ac_r[17])
					|| (instr_r[aug_exec_pkg::SK_NOOVF] && !ovf_r)
					|| (instr_r[aug_exec_pkg::SK_IOPLUS] && !io_r[17])
					|| (instr_r[5:3] != 3'h0 && sw_hit)
					|| (instr_r[2:0] != 3'h0 && fl_hit);
				skip_take = skip_take ^ instr_r[aug_exec_pkg::B_IND];
				szo_clr   = instr_r[aug_exec_pkg::SK_NOOVF];
			end
			aug_exec_pkg::OP_OPR: begin
				// clears, then OR loads, then complement
				if (instr_r[aug_exec_pkg::OP_CLI])
					io_nxt = 18'h0_0000;
				if (instr_r[aug_exec_pkg::OP_CLA])
					ac_nxt = 18'h0_0000;
				if (instr_r[aug_exec_pkg::OP_LAT])
					ac_nxt = ac_nxt | i_test_word_switches;
				if (instr_r[aug_exec_pkg::OP_LAP])
					ac_nxt = ac_nxt | {ovf_r, i_extend_mode, i_extended_pc,
						pc_r + 12'h001};
				if (instr_r[aug_exec_pkg::OP_CMA])
					ac_nxt = ~ac_nxt;
				halt_go = instr_r[aug_exec_pkg::OP_HLT];
				if (instr_r[aug_exec_pkg::OP_STF])
					flags_nxt = flags_r | sel_mask(instr_r[2:0]);
				else
					flags_nxt = flags_r & ~sel_mask(instr_r[2:0]);
			end
			aug_exec_pkg::OP_IOT: begin
				go_wait = instr_r[aug_exec_pkg::B_IND];
				dev_op  = instr_r[11:0] != 12'h000;
			end
			default: ;
		endcase
	end

	// sequencer: idle, one memory cycle of execution, in-out wait
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			state_r <= aug_exec_pkg::ST_IDLE;
			cnt_r   <= '0;
		end else begin
			unique case (state_r)
				aug_exec_pkg::ST_IDLE:
					if (wr_go && awaddr_r == aug_exec_pkg::ADDR_INSTR && !halted_r) begin
						state_r <= aug_exec_pkg::ST_EXEC;
						cnt_r   <= aug_exec_pkg::CNT_W'(EXEC_LAST);
					end
				aug_exec_pkg::ST_EXEC:
					if (cnt_r != '0)
						cnt_r <= cnt_r - 1'b1;
					else if (go_wait)
						state_r <= aug_exec_pkg::ST_WAIT;
					else
						state_r <= aug_exec_pkg::ST_IDLE;
				aug_exec_pkg::ST_WAIT:
					if (pend_r)
						state_r <= aug_exec_pkg::ST_IDLE;
				default:
					state_r <= aug_exec_pkg::ST_IDLE;
			endcase
		end
	end

	// break and channel requests are acknowledged without leaving the wait
	assign o_service_ack = (state_r == aug_exec_pkg::ST_WAIT) && (i_break_req || i_hs_req);

	// instruction latch
	always_ff @(posedge i_clk) begin
		if (i_reset)
			instr_r <= 18'h0_0000;
		else if (idle && wr_go && awaddr_r == aug_exec_pkg::ADDR_INSTR && !halted_r)
			instr_r <= wr_val[17:0];
	end

	// accumulator, in-out register and flags
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			ac_r    <= 18'h0_0000;
			io_r    <= 18'h0_0000;
			flags_r <= 6'h00;
		end else if (commit) begin
			ac_r    <= ac_nxt;
			io_r    <= io_nxt;
			flags_r <= flags_nxt;
		end else if (idle && wr_go) begin
			if (awaddr_r == aug_exec_pkg::ADDR_AC)
				ac_r <= wr_val[17:0];
			if (awaddr_r == aug_exec_pkg::ADDR_IO)
				io_r <= wr_val[17:0];
		end
	end

	// program counter: one step, two on a skip, held until the wait ends
	always_ff @(posedge i_clk) begin
		if (i_reset)
			pc_r <= 12'h000;
		else if (commit && !go_wait)
			pc_r <= pc_r + (skip_take ? 12'h002 : 12'h001);
		else if (state_r == aug_exec_pkg::ST_WAIT && pend_r)
			pc_r <= pc_r + 12'h001;
		else if (idle && wr_go && awaddr_r == aug_exec_pkg::ADDR_PC)
			pc_r <= wr_val[11:0];
	end

	// overflow: arithmetic set wins over any clear
	always_ff @(posedge i_clk) begin
		if (i_reset)
			ovf_r <= 1'b0;
		else if (i_add_overflow)
			ovf_r <= 1'b1;
		else if (i_console_start || (commit && szo_clr))
			ovf_r <= 1'b0;
	end

	// halt stops execution until the console start
	always_ff @(posedge i_clk) begin
		if (i_reset)
			halted_r <= 1'b0;
		else if (commit && halt_go)
			halted_r <= 1'b1;
		else if (i_console_start)
			halted_r <= 1'b0;
	end

	// completion bookkeeping: expect, then record the pulse
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			expect_r <= 1'b0;
			pend_r   <= 1'b0;
		end else begin
			if (commit && dev_op && (instr_r[aug_exec_pkg::B_IND] ^ instr_r[aug_exec_pkg::B_SIX]))
				expect_r <= 1'b1;
			else if (i_io_complete)
				expect_r <= 1'b0;
			if (i_io_complete && expect_r)
				pend_r <= 1'b1;
			else if (state_r == aug_exec_pkg::ST_WAIT)
				pend_r <= 1'b0;
		end
	end

	// device command strobe at the end of the memory cycle
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_iot_strobe  <= 1'b0;
			o_iot_command <= 12'h000;
		end else begin
			o_iot_strobe <= commit && dev_op;
			if (commit && dev_op)
				o_iot_command <= instr_r[11:0];
		end
	end

	// axi4-lite write side: address and data taken in either order
	assign wr_val = merge(32'h0000_0000, wdata_r, wstrb_r);
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			aw_full_r <= 1'b0;
			w_full_r  <= 1'b0;
			bvalid_r  <= 1'b0;
			bresp_r   <= aug_exec_pkg::RESP_OKAY;
			awaddr_r  <= 8'h00;
			wdata_r   <= 32'h0000_0000;
			wstrb_r   <= 4'h0;
		end else begin
			if (i_awvalid && o_awready) begin
				aw_full_r <= 1'b1;
				awaddr_r  <= i_awaddr;
			end
			if (i_wvalid && o_wready) begin
				w_full_r <= 1'b1;
				wdata_r  <= i_wdata;
				wstrb_r  <= i_wstrb;
			end
			if (wr_go) begin
				aw_full_r <= 1'b0;
				w_full_r  <= 1'b0;
				bvalid_r  <= 1'b1;
				if ((awaddr_r == aug_exec_pkg::ADDR_INSTR && idle && !halted_r)
					|| (idle && (awaddr_r == aug_exec_pkg::ADDR_AC
					|| awaddr_r == aug_exec_pkg::ADDR_IO || awaddr_r == aug_exec_pkg::ADDR_PC)))
					bresp_r <= aug_exec_pkg::RESP_OKAY;
				else
					bresp_r <= aug_exec_pkg::RESP_SLVERR;
			end else if (bvalid_r && i_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end
	assign o_awready = !aw_full_r && !bvalid_r;
	assign o_wready  = !w_full_r && !bvalid_r;
	assign o_bvalid  = bvalid_r;
	assign o_bresp   = bresp_r;

	// axi4-lite read side
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h0000_0000;
			rresp_r  <= aug_exec_pkg::RESP_OKAY;
		end else if (i_arvalid && o_arready) begin
			rvalid_r <= 1'b1;
			rresp_r  <= aug_exec_pkg::RESP_OKAY;
			unique case (i_araddr)
				aug_exec_pkg::ADDR_INSTR:  rdata_r <= {14'h0000, instr_r};
				aug_exec_pkg::ADDR_AC:     rdata_r <= {14'h0000, ac_r};
				aug_exec_pkg::ADDR_IO:     rdata_r <= {14'h0000, io_r};
				aug_exec_pkg::ADDR_PC:     rdata_r <= {20'h0_0000, pc_r};
				aug_exec_pkg::ADDR_STATUS: rdata_r <= {20'h0_0000, pend_r, expect_r,
					state_r == aug_exec_pkg::ST_WAIT, !idle, halted_r, ovf_r, flags_r};
				default: begin
					rdata_r <= 32'h0000_0000;
					rresp_r <= aug_exec_pkg::RESP_SLVERR;
				end
			endcase
		end else if (rvalid_r && i_rready) begin
			rvalid_r <= 1'b0;
		end
	end
	assign o_arready = !rvalid_r;
	assign o_rvalid  = rvalid_r;
	assign o_rdata   = rdata_r;
	assign o_rresp   = rresp_r;

	// visible state
	assign o_ac       = ac_r;
	assign o_io       = io_r;
	assign o_pc       = pc_r;
	assign o_flags    = flags_r;
	assign o_overflow = ovf_r;
	assign o_halted   = halted_r;
	assign o_waiting  = (state_r == aug_exec_pkg::ST_WAIT);

	// checks
	sequence s_exec_start;
		$rose(state_r == aug_exec_pkg::ST_EXEC);
	endsequence
	sequence s_wait_issue;
		commit && op == aug_exec_pkg::OP_IOT && instr_r[aug_exec_pkg::B_IND];
	endsequence

	a_exec_one_cycle: assert property (@(posedge i_clk) disable iff (i_reset)
		s_exec_start |-> ##[EXEC_LAST:EXEC_LAST] commit)
		else $error("execution does not last one memory cycle");
	a_wait_entered: assert property (@(posedge i_clk) disable iff (i_reset)
		s_wait_issue |=> (state_r == aug_exec_pkg::ST_WAIT) && pc_r == $past(pc_r))
		else $error("wait not entered on bit 5 transfer");
	a_wait_release: assert property (@(posedge i_clk) disable iff (i_reset)
		(state_r == aug_exec_pkg::ST_WAIT) && pend_r |=> idle && pc_r == $past(pc_r) + 12'h001)
		else $error("recorded completion did not release wait");
	a_szo_clears: assert property (@(posedge i_clk) disable iff (i_reset)
		commit && op == aug_exec_pkg::OP_SKIP && instr_r[aug_exec_pkg::SK_NOOVF]
		&& !i_add_overflow |=> !ovf_r)
		else $error("no-overflow skip left overflow set");
	a_ovf_sticky: assert property (@(posedge i_clk) disable iff (i_reset)
		ovf_r && !i_console_start && !commit |=> ovf_r)
		else $error("overflow dropped without a clearing cause");
	a_skip_steps: assert property (@(posedge i_clk) disable iff (i_reset)
		commit && op == aug_exec_pkg::OP_SKIP |=> pc_r == $past(pc_r) + ($past(skip_take)
		? 12'h002 : 12'h001))
		else $error("skip advanced the counter wrongly");
	a_skip_invert: assert property (@(posedge i_clk) disable iff (i_reset)
		commit && op == aug_exec_pkg::OP_SKIP && instr_r[aug_exec_pkg::B_IND]
		&& instr_r[11:0] == (12'h001 << aug_exec_pkg::SK_ZERO)
		|=> pc_r == $past(pc_r) + (($past(ac_r) == 18'h0_0000) ? 12'h001 : 12'h002))
		else $error("inverted zero skip stepped the counter wrongly");
	a_halt_blocks: assert property (@(posedge i_clk) disable iff (i_reset)
		halted_r && !i_console_start |=> state_r != aug_exec_pkg::ST_EXEC)
		else $error("execution started while halted");
	a_cli_clears: assert property (@(posedge i_clk) disable iff (i_reset)
		commit && op == aug_exec_pkg::OP_OPR && instr_r[aug_exec_pkg::OP_CLI]
		|=> io_r == 18'h0_0000)
		else $error("in-out register not cleared");
	a_no_expect_equal: assert property (@(posedge i_clk) disable iff (i_reset)
		commit && op == aug_exec_pkg::OP_IOT && !expect_r && (instr_r[aug_exec_pkg::B_IND]
		== instr_r[aug_exec_pkg::B_SIX]) |=> !expect_r)
		else $error("completion expected with equal bits 5 and 6");
endmodule // augmented_instruction_exec

// ==== include/aug_exec_pkg.sv ====
// constants, encodings and register map of the augmented instruction executor
package aug_exec_pkg;
	// timing: one memory cycle per executed instruction
	localparam int CLK_PERIOD_PS  = 8000;
	localparam int MEM_CYCLE_US   = 5;
	localparam int MEM_CYCLES     = (MEM_CYCLE_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CNT_W          = 10;

	// major operation codes, instruction bits 0..4 (vector bits 17..13)
	localparam logic [4:0] OP_SHIFT = 5'h1b;
	localparam logic [4:0] OP_SKIP  = 5'h1a;
	localparam logic [4:0] OP_OPR   = 5'h1f;
	localparam logic [4:0] OP_IOT   = 5'h1d;

	// vector index of instruction bit 5 and bit 6
	localparam int B_IND  = 12;
	localparam int B_SIX  = 11;
	// shift group: bit 5 picks right, bit 6 picks arithmetic, bits 7..8 the unit
	localparam int SH_RIGHT = 12;
	localparam int SH_ARITH = 11;
	localparam logic [1:0] UNIT_AC   = 2'h1;
	localparam logic [1:0] UNIT_IO   = 2'h2;
	localparam logic [1:0] UNIT_PAIR = 2'h3;
	localparam int SH_STEPS = 9;
	// skip group select bits
	localparam int SK_ZERO   = 6;
	localparam int SK_PLUS   = 7;
	localparam int SK_MINUS  = 8;
	localparam int SK_NOOVF  = 9;
	localparam int SK_IOPLUS = 10;
	// operate group bits
	localparam int OP_LAP = 6;
	localparam int OP_CLA = 7;
	localparam int OP_HLT = 8;
	localparam int OP_CMA = 9;
	localparam int OP_LAT = 10;
	localparam int OP_CLI = 11;
	localparam int OP_STF = 3;
	localparam logic [2:0] SEL_ALL = 3'h7;

	// register byte addresses
	localparam logic [7:0] ADDR_INSTR  = 8'h00;
	localparam logic [7:0] ADDR_AC     = 8'h04;
	localparam logic [7:0] ADDR_IO     = 8'h08;
	localparam logic [7:0] ADDR_PC     = 8'h0c;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_EXEC = 2'h1,
		ST_WAIT = 2'h3
	} state_t;
endpackage

// ==== tb/io_device_model.sv ====
// peripheral model that answers each transfer strobe with a completion pulse
`timescale 1ns/10ps
module io_device_model (
	// clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_reset,
	// transfer strobe from the executor and the reply delay in cycles
	input  wire logic       i_strobe,
	input  wire logic [7:0] i_delay,
	// completion pulse back to the executor
	output logic            o_complete
);
	int count_r;

	// count down the reply delay, then pulse completion for one cycle
	always @(posedge i_clk) begin
		o_complete <= 1'b0;
		if (i_reset) begin
			count_r <= 0;
		end else if (i_strobe) begin
			count_r <= int'(i_delay);
		end else if (count_r > 1) begin
			count_r <= count_r - 1;
		end else if (count_r == 1) begin
			count_r <= 0;
			o_complete <= 1'b1;
		end
	end
endmodule // io_device_model

// ==== tb/augmented_instruction_exec_tb_top.sv ====
// self-checking bench for the augmented instruction executor
`timescale 1ns/10ps
module augmented_instruction_exec_tb_top;
	localparam logic [7:0] A_IN = aug_exec_pkg::ADDR_INSTR;
	localparam logic [7:0] A_AC = aug_exec_pkg::ADDR_AC;
	localparam logic [7:0] A_IO = aug_exec_pkg::ADDR_IO;
	localparam logic [7:0] A_PC = aug_exec_pkg::ADDR_PC;
	localparam logic [7:0] A_ST = aug_exec_pkg::ADDR_STATUS;
	localparam logic [1:0] OK = aug_exec_pkg::RESP_OKAY;
	localparam logic [1:0] ERR = aug_exec_pkg::RESP_SLVERR;
	logic        i_clk = 1'b0;
	logic        i_reset = 1'b1;
	logic        i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
	logic        i_arvalid = 1'b0, i_rready = 1'b0;
	logic [7:0]  i_awaddr = '0, i_araddr = '0;
	logic [31:0] i_wdata = '0;
	logic [3:0]  i_wstrb = '0;
	logic        i_console_start = 1'b0, i_add_overflow = 1'b0, i_extend_mode = 1'b0;
	logic        i_break_req = 1'b0, i_hs_req = 1'b0;
	logic [17:0] i_test_word_switches = '0;
	logic [5:0]  i_sense_switches = '0;
	logic [3:0]  i_extended_pc = '0;
	logic [7:0]  dly = 8'h28;
	logic        i_io_complete;
	logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_service_ack;
	logic        o_iot_strobe, o_overflow, o_halted, o_waiting;
	logic [1:0]  o_bresp, o_rresp;
	logic [31:0] o_rdata;
	logic [11:0] o_iot_command, o_pc;
	logic [17:0] o_ac, o_io;
	logic [5:0]  o_flags;
	int          failures = 0, total_checks = 0, strobes = 0, dur = 0;

	augmented_instruction_exec dut (.*);
	io_device_model dev (.i_clk(i_clk), .i_reset(i_reset), .i_strobe(o_iot_strobe),
		.i_delay(dly), .o_complete(i_io_complete));

	// clock and strobe counter
	always #4 i_clk = ~i_clk;
	always @(posedge i_clk) if (o_iot_strobe === 1'b1) strobes <= strobes + 1;

	task automatic check(input logic [35:0] got, input logic [35:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one write: address and data offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ah, wh, bh;
		logic [1:0] rsp;
		int n;
		bh = 1'b0;
		rsp = 2'h1;
		n = 0;
		@(posedge i_clk);
		i_awaddr <= a;
		i_wdata <= d;
		i_wstrb <= 4'hf;
		i_awvalid <= 1'b1;
		i_wvalid <= 1'b1;
		i_bready <= 1'b1;
		while (!bh && n < 100) begin
			@(negedge i_clk);
			ah = i_awvalid & o_awready;
			wh = i_wvalid & o_wready;
			bh = i_bready & o_bvalid;
			rsp = o_bresp;
			@(posedge i_clk);
			if (ah) i_awvalid <= 1'b0;
			if (wh) i_wvalid <= 1'b0;
			if (bh) i_bready <= 1'b0;
			n++;
		end
		check(rsp, er);
	endtask

	// one read, data and response taken at the rvalid handshake edge
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic arh, rh;
		int n;
		rh = 1'b0;
		n = 0;
		@(posedge i_clk);
		i_araddr <= a;
		i_arvalid <= 1'b1;
		i_rready <= 1'b1;
		while (!rh && n < 100) begin
			@(negedge i_clk);
			arh = i_arvalid & o_arready;
			rh = i_rready & o_rvalid;
			d = o_rdata;
			r = o_rresp;
			@(posedge i_clk);
			if (arh) i_arvalid <= 1'b0;
			if (rh) i_rready <= 1'b0;
			n++;
		end
		if (!rh) failures++;
	endtask

	// start an instruction, wait until the counter moves or the wait state begins
	task automatic ex(input logic [17:0] ins);
		logic [11:0] p;
		int n;
		p = o_pc;
		n = 0;
		wr(A_IN, {14'h0, ins}, OK);
		while (o_pc === p && o_waiting !== 1'b1 && n < 2000) begin
			@(negedge i_clk);
			n++;
		end
		if (n >= 2000) failures++;
		dur = n;
		@(posedge i_clk);
	endtask

	task automatic ld(input logic [17:0] a, input logic [17:0] b, input logic [11:0] p);
		wr(A_AC, {14'h0, a}, OK);
		wr(A_IO, {14'h0, b}, OK);
		wr(A_PC, {20'h0, p}, OK);
	endtask

	// skip case: counter starts at 0x010 and must land one or two further
	task automatic sk(input logic [17:0] a, input logic [17:0] b, input logic [5:0] sw,
		input logic [17:0] ins, input logic s);
		i_sense_switches <= sw;
		ld(a, b, 12'h010);
		ex(ins);
		check(o_pc, s ? 12'h012 : 12'h011);
	endtask

	task automatic pulse_ovf();
		@(posedge i_clk);
		i_add_overflow <= 1'b1;
		@(posedge i_clk);
		i_add_overflow <= 1'b0;
	endtask

	task automatic pulse_start();
		@(posedge i_clk);
		i_console_start <= 1'b1;
		@(posedge i_clk);
		i_console_start <= 1'b0;
		@(negedge i_clk);
	endtask

	// reference shifter: 0/1 ring right/left, 2/3 pair arithmetic, 5 accumulator arithmetic
	// right, else in-out left
	function automatic logic [35:0] shf(input logic [35:0] v, input int n, input int m);
		for (int i = 0; i < n; i++) begin
			case (m)
				0: v = {v[0], v[35:1]};
				1: v = {v[34:0], v[35]};
				2: v = {v[35], v[35], v[34:1]};
				3: v = {v[35], v[33:0], v[35]};
				5: v = {v[35], v[35], v[34:19], v[17:0]};
				default: v = {v[35:18], v[17], v[15:0], v[17]};
			endcase
		end
		return v;
	endfunction

	task automatic t_regs();
		logic [31:0] d;
		logic [1:0] r;
		rd(A_ST, d, r);
		check(d, 32'h0);
		rd(8'h20, d, r);
		check(r, ERR);
		wr(8'h24, 32'h0000_0001, ERR);
		wr(A_PC, 32'h0000_0abc, OK);
		rd(A_PC, d, r);
		check(d, 32'h0000_0abc);
	endtask

	task automatic t_shift();
		logic [17:0] ins [6] = '{18'o666003, 18'o673777, 18'o663421, 18'o677001, 18'o667500,
			18'o675003};
		int md [6] = '{4, 0, 1, 2, 3, 5};
		int cnt [6] = '{2, 9, 3, 1, 2, 2};
		logic [35:0] v0 = {18'h2_1234, 18'h2_0f0f};
		for (int i = 0; i < 6; i++) begin
			ld(18'h2_1234, 18'h2_0f0f, 12'h000);
			ex(ins[i]);
			check({o_ac, o_io}, shf(v0, cnt[i], md[i]));
		end
	endtask

	task automatic t_skip();
		sk(18'h0, '0, '0, 18'o640100, 1'b1);
		sk(18'h2_0000, '0, '0, 18'o640200, 1'b0);
		sk(18'h2_0000, '0, '0, 18'o640400, 1'b1);
		sk(18'h1, 18'h2_0000, '0, 18'o642000, 1'b0);
		sk(18'h1, 18'h1, '0, 18'o642000, 1'b1);
		sk(18'h1, 18'h2_0000, '0, 18'o643500, 1'b1);
		check(dur >= 620 && dur <= 626, 1'b1);
		sk(18'h0, '0, '0, 18'o650100, 1'b0);
		sk(18'h1, '0, '0, 18'o650100, 1'b1);
		sk(18'h1, '0, 6'h04, 18'o640030, 1'b0);
		sk(18'h1, '0, 6'h04, 18'o640020, 1'b1);
		sk(18'h1, '0, 6'h20, 18'o640070, 1'b0);
		sk(18'h1, '0, 6'h00, 18'o640070, 1'b1);
		sk(18'h1, '0, '0, 18'o640007, 1'b1);
	endtask

	task automatic t_ovf();
		pulse_ovf();
		ex(18'o760000);
		check(o_overflow, 1'b1);
		sk(18'h1, '0, '0, 18'o641000, 1'b0);
		check(o_overflow, 1'b0);
		sk(18'h1, '0, '0, 18'o641000, 1'b1);
		pulse_ovf();
		pulse_start();
		check(o_overflow, 1'b0);
	endtask

	task automatic t_opr();
		i_test_word_switches <= 18'h1_2345;
		ld(18'h0_00f0, 18'h3_ffff, 12'h000);
		ex(18'o762000);
		check(o_ac, 18'h1_23f5);
		ex(18'o763200);
		check(o_ac, 18'h2_dcba);
		ex(18'o761000);
		check(o_ac, 18'h1_2345);
		ex(18'o764200);
		check({o_ac, o_io}, 36'h0);
		i_extend_mode <= 1'b1;
		i_extended_pc <= 4'ha;
		pulse_ovf();
		ld(18'h0_0f00, 18'h0, 12'h123);
		ex(18'o760300);
		check(o_ac, {2'b11, 4'ha, 12'h124});
		pulse_start();
		ex(18'o760017);
		check(o_flags, 6'h3f);
		ex(18'o760003);
		check(o_flags, 6'h3b);
		sk(18'h1, '0, '0, 18'o640003, 1'b1);
		sk(18'h1, '0, '0, 18'o640002, 1'b0);
		sk(18'h1, '0, '0, 18'o640007, 1'b0);
		ex(18'o760007);
		check(o_flags, 6'h00);
		ex(18'o760014);
		check(o_flags, 6'h08);
	endtask

	task automatic t_halt();
		logic [11:0] p;
		ex(18'o760400);
		check(o_halted, 1'b1);
		p = o_pc;
		wr(A_IN, {14'h0, 18'o760000}, ERR);
		repeat (5) @(posedge i_clk);
		check(o_pc, p);
		pulse_start();
		check(o_halted, 1'b0);
	endtask

	task automatic t_iot();
		logic [31:0] d;
		logic [1:0] r;
		logic [11:0] p;
		int s, n;
		ld('0, '0, 12'h020);
		ex(18'o730003);
		check({o_waiting, o_pc}, {1'b1, 12'h020});
		@(posedge i_clk);
		i_break_req <= 1'b1;
		@(negedge i_clk);
		check(o_service_ack, 1'b1);
		@(posedge i_clk);
		i_break_req <= 1'b0;
		i_hs_req <= 1'b1;
		@(negedge i_clk);
		check(o_service_ack, 1'b1);
		@(posedge i_clk);
		i_hs_req <= 1'b0;
		n = 0;
		while (o_waiting !== 1'b0 && n < 200) begin
			@(negedge i_clk);
			n++;
		end
		repeat (2) @(negedge i_clk);
		check({o_pc, o_iot_command}, {12'h021, 12'o0003});
		dly <= 8'h03;
		s = strobes;
		ex(18'o724005);
		repeat (10) @(posedge i_clk);
		rd(A_ST, d, r);
		check({d[11], 32'(strobes)}, {1'b1, 32'(s + 1)});
		s = strobes;
		p = o_pc;
		ex(18'o730000);
		repeat (3) @(negedge i_clk);
		check({o_waiting, o_pc, 8'(strobes)}, {1'b0, p + 12'h001, 8'(s)});
		ex(18'o720005);
		repeat (10) @(posedge i_clk);
		rd(A_ST, d, r);
		check({d[11:10], 32'(strobes)}, {2'b00, 32'(s + 1)});
	endtask

	task automatic results();
		$display("checks=%0d failures=%0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// main sequence after five cycles of reset
	initial begin
		repeat (5) @(posedge i_clk);
		i_reset <= 1'b0;
		t_regs();
		t_shift();
		t_skip();
		t_ovf();
		t_opr();
		t_halt();
		t_iot();
		results();
	end

	// watchdog against a hung handshake or wait
	initial begin
		repeat (60000) @(posedge i_clk);
		failures++;
		results();
	end
endmodule // augmented_instruction_exec_tb_top
